// ---- adcsc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Sample FIFO
// ****************************************
module adcsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign o_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign o_valid = (cnt_reg != '0);
  assign o_data = mem[rd_reg];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  // Storage, no reset needed on data
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_reg] <= i_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // adcsc_fifo

// ****************************************
// Converter control
// ****************************************
module adcsc_ctrl #(
  parameter int BITS = adcsc_pkg::ADCSC_BITS
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  // Host pins
  input wire logic i_SCK,
  input wire logic i_CONVERT_START_STROBE,
  // Digitised analog inputs
  input wire logic [adcsc_pkg::ADCSC_BITS-1:0] i_AIN_POS,
  input wire logic [adcsc_pkg::ADCSC_BITS-1:0] i_AIN_NEG,
  // Serial data pin
  output logic o_SDO,
  output logic o_SDO_OE,
  // Status
  output logic o_HOLD,
  output logic [1:0] o_MODE,
  output logic o_OVERRUN
);
  import adcsc_pkg::*;

  logic [2:0] sck_sync;
  logic [2:0] cnv_sync;
  logic sck_lvl_reg;
  logic cnv_lvl_reg;
  logic sck_rise;
  logic cnv_rise;
  adcsc_mode_e mode_reg;
  logic [2:0] pulse_reg;
  logic [4:0] cnt_reg;
  logic busy_reg;
  logic [BITS-1:0] shift_reg;
  logic [BITS-1:0] diff_now;
  adcsc_sample_s samp;
  logic f_ready;
  logic f_valid;
  logic [2*BITS-1:0] f_data;
  logic start;

  // Three-stage sync; a change counts once stages two and three agree
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      sck_sync <= 3'h0;
      cnv_sync <= 3'h0;
      sck_lvl_reg <= 1'b0;
      cnv_lvl_reg <= 1'b0;
    end else begin
      sck_sync <= {sck_sync[1:0], i_SCK};
      cnv_sync <= {cnv_sync[1:0], i_CONVERT_START_STROBE};
      if (sck_sync[1] == sck_sync[2]) begin
        sck_lvl_reg <= sck_sync[2];
      end
      if (cnv_sync[1] == cnv_sync[2]) begin
        cnv_lvl_reg <= cnv_sync[2];
      end
    end
  end

  assign sck_rise = sck_sync[1] && sck_sync[2] && !sck_lvl_reg;
  assign cnv_rise = cnv_sync[1] && cnv_sync[2] && !cnv_lvl_reg;
  // Busy frames ignore strobes; a full FIFO also stalls starts
  assign start = cnv_rise && !busy_reg && mode_reg == ADCSC_ACTIVE && f_ready; // RULE_10

  // Both inputs captured on the same edge
  assign samp.pos = i_AIN_POS; // RULE_08
  assign samp.neg = i_AIN_NEG; // RULE_08

  adcsc_fifo #(.WIDTH(2*BITS), .DEPTH(ADCSC_FIFO_DEPTH)) u_fifo (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_valid(start),
    .o_ready(f_ready),
    .i_data(samp),
    .o_valid(f_valid),
    .i_ready(start),
    .o_data(f_data)
  );
  // Unsigned difference, clamped to zero when negative
  assign diff_now = (f_data[2*BITS-1:BITS] > f_data[BITS-1:0]) ?
                    f_data[2*BITS-1:BITS] - f_data[BITS-1:0] : '0;

  // Shutdown mode; reset comes up active
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      mode_reg <= ADCSC_ACTIVE; // RULE_13
      pulse_reg <= 3'h0;
    end else if (sck_rise) begin
      pulse_reg <= 3'h0; // RULE_14
      mode_reg <= ADCSC_ACTIVE; // RULE_07 RULE_15
    end else if (cnv_rise) begin
      // Saturate so long idle strobe trains stay in sleep
      if (pulse_reg != 3'h7) begin
        pulse_reg <= pulse_reg + 3'h1;
      end
      if (pulse_reg + 3'h1 >= ADCSC_SLEEP_PULSES) begin
        mode_reg <= ADCSC_SLEEP; // RULE_06
      end else if (pulse_reg + 3'h1 >= ADCSC_NAP_PULSES) begin
        mode_reg <= ADCSC_NAP; // RULE_05
      end
    end
  end

  // Frame counter and output shifter
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      cnt_reg <= ADCSC_CNT_RST;
      busy_reg <= 1'b0;
      shift_reg <= '0;
      o_SDO <= 1'b0;
      o_SDO_OE <= 1'b0;
      o_HOLD <= 1'b0;
    end else if (start) begin
      busy_reg <= 1'b1; // RULE_04
      o_HOLD <= 1'b1; // RULE_04
      cnt_reg <= ADCSC_CNT_RST;
      // Previous conversion's sample goes out, when one exists
      shift_reg <= f_valid ? diff_now : '0; // RULE_02
      o_SDO_OE <= 1'b0;
    end else if (busy_reg && sck_rise) begin
      cnt_reg <= cnt_reg + 5'h1; // RULE_03
      if (cnt_reg < 5'(BITS)) begin
        o_SDO <= shift_reg[BITS-1]; // RULE_03 RULE_12
        shift_reg <= {shift_reg[BITS-2:0], 1'b0};
        o_SDO_OE <= 1'b1;
      end else begin
        o_SDO <= 1'b0;
        o_SDO_OE <= 1'b0; // RULE_01
      end
      if (cnt_reg == 5'(ADCSC_FRAME - 1)) begin
        busy_reg <= 1'b0; // RULE_10
        o_HOLD <= 1'b0;
      end
    end
  end

  // Registered mode and overrun status
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      o_MODE <= 2'h0;
      o_OVERRUN <= 1'b0;
    end else begin
      o_MODE <= mode_reg;
      o_OVERRUN <= cnv_rise && busy_reg;
    end
  end

  // ****************************************
  // Frame and shutdown checks
  // ****************************************

  // A strobe edge with the serial clock quiet in the same cycle
  sequence s_idle_strobe;
    cnv_rise && !sck_rise;
  endsequence

  // A serial clock edge inside a running frame
  sequence s_frame_edge;
    busy_reg && sck_rise;
  endsequence

  // Output released whenever no frame is running
  a_sdo_idle_hiz: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    !busy_reg |=> !o_SDO_OE) else $error("SDO driven outside frame"); // RULE_01
  a_busy_ignores_cnv: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    busy_reg && cnv_rise && !sck_rise |=> busy_reg) else $error("strobe cut frame"); // RULE_10
  a_start_sets_hold: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    start |=> o_HOLD && busy_reg && cnt_reg == 5'h0) else $error("start missed"); // RULE_04
  a_sck_wakes: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    sck_rise |=> mode_reg == ADCSC_ACTIVE && pulse_reg == 3'h0) else $error("no wake"); // RULE_07
  a_nap_entry: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    pulse_reg == 3'h1 ##0 s_idle_strobe |=> mode_reg == ADCSC_NAP)
    else $error("nap not entered"); // RULE_05
  a_sleep_entry: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    pulse_reg == 3'h3 ##0 s_idle_strobe |=> mode_reg == ADCSC_SLEEP)
    else $error("sleep not entered"); // RULE_06
  a_count_advance: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    busy_reg && sck_rise && !start |=> cnt_reg == $past(cnt_reg) + 5'h1)
    else $error("count stuck"); // RULE_03
  a_frame_bound: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    busy_reg |-> cnt_reg <= 5'(ADCSC_FRAME - 1)) else $error("frame overlong"); // RULE_12

  // Data bits are driven on the first edges of a frame
  a_sdo_bits_driven: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_01
    s_frame_edge ##0 cnt_reg < 5'(BITS) |=> o_SDO_OE)
    else $error("data bit not driven");

  // Tail edges of a frame release the line
  a_sdo_tail_hiz: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_01
    s_frame_edge ##0 cnt_reg >= 5'(BITS) |=> !o_SDO_OE)
    else $error("line held in frame tail");

  // The line stays released between start and the first edge
  a_start_released: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_01
    start |=> !o_SDO_OE)
    else $error("line driven at start");

  // First bit out is the top bit of the loaded word
  a_first_bit: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_02
    s_frame_edge ##0 cnt_reg == 5'h0 |=> o_SDO == $past(shift_reg[BITS-1]))
    else $error("wrong first bit");

  // Sixteenth edge closes the frame and opens acquisition
  a_frame_end: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_10
    s_frame_edge ##0 cnt_reg == 5'(ADCSC_FRAME - 1) |=> !busy_reg && !o_HOLD)
    else $error("frame did not end");

  // Hold pin mirrors the busy state exactly
  a_hold_tracks_busy: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_04
    o_HOLD == busy_reg)
    else $error("hold and busy differ");

  // Strobes inside a frame are flagged and start no conversion, though they count towards nap and sleep
  a_overrun_flag: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_10
    busy_reg && cnv_rise |=> o_OVERRUN)
    else $error("overrun not flagged");

  // Shutdown modes never start a conversion
  a_nap_blocks_start: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_05
    mode_reg != ADCSC_ACTIVE |-> !start)
    else $error("start while shut down");

  // Sleep lasts until a serial clock edge arrives
  a_sleep_holds: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_06
    mode_reg == ADCSC_SLEEP && !sck_rise |=> mode_reg == ADCSC_SLEEP)
    else $error("sleep left early");

  // One edge is enough to leave nap
  a_nap_wake: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_15
    mode_reg == ADCSC_NAP && sck_rise |=> mode_reg == ADCSC_ACTIVE)
    else $error("nap not left");

  // Mode pin trails the internal mode by one cycle
  a_mode_follows: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_13
    o_MODE == $past(mode_reg))
    else $error("mode pin out of step");
endmodule // adcsc_ctrl

`default_nettype wire

// ---- adcsc_pkg.sv ----
// Functional notes
// RULE_01 - Results leave on a three-state serial output that is released whenever no data bit is shown.
// RULE_02 - Each shifted word is the input difference captured at the start of the previous conversion.
// RULE_03 - Conversion steps and output bits advance on each rising serial clock edge.
// RULE_04 - A rising convert strobe freezes the input into hold and starts a new conversion.
// RULE_05 - Two convert strobes with the serial clock held steady select nap mode.
// RULE_06 - Four or more convert strobes with the serial clock held steady select sleep mode.
// RULE_07 - One or more serial clock pulses wake the device from sleep.
// RULE_08 - Both analog inputs are captured together at one sampling instant.
// RULE_09 - The controller spaces strobes further apart when a slow input driver is used.
// RULE_10 - Strobe edges are ignored until sixteen serial clock edges follow a conversion start; the code still counts them towards nap and sleep.
// RULE_11 - The controller adds two serial clock periods between conversions for acquisition.
// RULE_12 - The whole output stream leaves within the first sixteen clock periods after a start.
// RULE_13 - After power-up the device is active and accepts a conversion with no wake sequence.
// RULE_14 - A serial clock edge between strobes clears the shutdown strobe count.
// RULE_15 - In nap mode one serial clock edge returns the device to the active state.
package adcsc_pkg;
  localparam int ADCSC_BITS = 14;
  localparam int ADCSC_FRAME = 16;
  localparam logic [4:0] ADCSC_CNT_RST = 5'h00;
  localparam logic [2:0] ADCSC_NAP_PULSES = 3'h2;
  localparam logic [2:0] ADCSC_SLEEP_PULSES = 3'h4;
  localparam int ADCSC_FIFO_DEPTH = 8;

  typedef enum logic [1:0] {
    ADCSC_ACTIVE = 2'b00,
    ADCSC_NAP = 2'b01,
    ADCSC_SLEEP = 2'b10
  } adcsc_mode_e;

  // Captured input pair, taken at one instant
  typedef struct packed {
    logic [ADCSC_BITS-1:0] pos;
    logic [ADCSC_BITS-1:0] neg;
  } adcsc_sample_s;
endpackage

// ---- adcsc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// Host controller model
// ****
module adcsc_host (
  // Clock and device pins
  input wire logic i_clk,
  input wire logic i_sdo,
  input wire logic i_sdo_oe,
  // Host pins
  output logic o_sck,
  output logic o_strobe
);
  logic [13:0] word;
  int rise = 0;
  int oe_bad = 0;
  // Clock and strobe idle low until a task drives them
  initial begin
    o_sck = 1'b0;
    o_strobe = 1'b0;
  end
  // Strobe pulse; restart realigns the bit count
  task automatic strobe_pulse(input bit restart);
    @(posedge i_clk) o_strobe <= 1'b1;
    if (restart) rise = 0;
    repeat (6) @(posedge i_clk);
    o_strobe <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
  // Slow SCK, read late in low phase to absorb pin lag
  task automatic clocks(input int n);
    repeat (n) begin
      @(posedge i_clk) o_sck <= 1'b1;
      rise++;
      repeat (6) @(posedge i_clk);
      o_sck <= 1'b0;
      repeat (5) @(posedge i_clk);
      @(negedge i_clk);
      if (rise <= 14) word[14-rise] = i_sdo;
      if (i_sdo_oe !== (rise <= 14)) oe_bad++;
    end
  endtask
endmodule // adcsc_host
`default_nettype wire

// ---- adcsc_ctrl_test.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// Converter control bench
// ****
module adcsc_ctrl_test;
  import adcsc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [13:0] pos = 14'h0000;
  logic [13:0] neg = 14'h0000;
  logic [13:0] prev;
  logic [13:0] want;
  logic sck, strobe, sdo, sdo_oe, hold, ovr;
  logic saw_ovr = 1'b0;
  logic [1:0] mode;
  int seed = 32'h800a76df;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  // Clock
  always #5 clk = ~clk;
  adcsc_ctrl i_adcsc_ctrl (.I_CLOCK(clk), .I_RST_N(rst_n), .i_SCK(sck),
    .i_CONVERT_START_STROBE(strobe), .i_AIN_POS(pos), .i_AIN_NEG(neg), .o_SDO(sdo),
    .o_SDO_OE(sdo_oe), .o_HOLD(hold), .o_MODE(mode), .o_OVERRUN(ovr));
  adcsc_host i_adcsc_host (.i_clk(clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe), .o_sck(sck),
    .o_strobe(strobe));
  // Expected word, clamped since negative differences read as zero
  function automatic logic [13:0] diff(input logic [13:0] p, input logic [13:0] n);
    return (p > n) ? p - n : 14'h0000;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Overrun lasts one cycle, so it is latched for the nap test
  always @(posedge clk) begin
    if (ovr === 1'b1) saw_ovr <= 1'b1;
  end
  // Run ceiling, far above the length of all tests
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      $display("timeout after %0d cycles", cycles);
      test_done();
    end
  end
  // One frame: set inputs, strobe, give eighteen clock edges to read fourteen bits
  task automatic frame(input logic [13:0] p, input logic [13:0] n);
    @(posedge clk);
    pos <= p;
    neg <= n;
    i_adcsc_host.strobe_pulse(1'b1);
    i_adcsc_host.clocks(18);
    check({2'b00, i_adcsc_host.word}, {2'b00, want});
    check({15'h0000, hold}, 16'h0000);
    want = diff(p, n);
  endtask
  initial begin
    want = 14'h0000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    check({14'h0000, mode}, 16'h0000);
    frame(14'h3FFF, 14'h0000);
    frame(14'h0005, 14'h0100);
    for (int t = 0; t < 10; t++) begin
      frame(14'($random(seed)), 14'($random(seed)));
    end
    $display("test stream done");
    // Second strobe lands in the frame of the first and counts towards nap
    i_adcsc_host.strobe_pulse(1'b1);
    i_adcsc_host.strobe_pulse(1'b0);
    repeat (4) @(posedge clk);
    check({14'h0000, mode}, 16'h0001);
    check({15'h0000, saw_ovr}, 16'h0001);
    i_adcsc_host.clocks(1);
    check({14'h0000, mode}, 16'h0000);
    i_adcsc_host.clocks(17);
    check({2'b00, i_adcsc_host.word}, {2'b00, want});
    i_adcsc_host.strobe_pulse(1'b1);
    repeat (3) i_adcsc_host.strobe_pulse(1'b0);
    repeat (4) @(posedge clk);
    check({14'h0000, mode}, 16'h0002);
    i_adcsc_host.clocks(18);
    check({14'h0000, mode}, 16'h0000);
    check({2'b00, i_adcsc_host.word}, {2'b00, want});
    $display("test shutdown done");
    // Reset in mid-run empties the sample store
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    check({14'h0000, mode}, 16'h0000);
    want = 14'h0000;
    frame(14'h0ABC, 14'h0001);
    check(16'(i_adcsc_host.oe_bad), 16'h0000);
    $display("test reset done");
    test_done();
  end
endmodule // adcsc_ctrl_test
`default_nettype wire
